//--- hw/usb_endpoint_mode_responder.sv
`timescale 1ns/1ps
// Functional notes
// R01: A 4-bit mode field per endpoint selects the answer to every token.
// R02: Mode 0000 gives no answer at all to SETUP, IN or OUT.
// R03: Mode 0001 accepts SETUP and NAKs both IN and OUT.
// R04: Modes 0010/0011/0100/0110 accept SETUP; IN and OUT per their table row.
// R05: 0101 always answers OUT only; 0111 sends counted data on IN only.
// R06: 1000 NAKs OUT, 1001 ACKs OUT, 1100 NAKs IN; SETUP ignored.
// R07: Modes 1010/1011/1110/1111 accept SETUP; IN and OUT per their table row.
// R08: 1101 sends counted data on IN; stall bit 7 stalls 1101 IN, 1001 OUT.
// R09: Status check ACKs only a zero-length DATA1 packet, else STALL or silence.
// R10: Counted data sends the endpoint count register's 4-bit byte count.
// R11: Zero-length reply answers IN with a packet carrying no bytes.
// R12: Ignored tokens get no handshake; SETUP is ACKed only when valid.
// R13: ACKed valid SETUP rewrites the mode to 0001 unless it was 0000.
// R14: ACKed OUT turns 1011 into 0001 and 1001 into 1000.
// R15: ACKed IN turns 1101 into 1100.
// R16: 1111 becomes 1110 after ACKed IN or ACKed status OUT.
// R17: Firmware writes a fresh mode after each automatic change.
// R18: Modes reset to 0000 and the engine never enables an endpoint itself.
// R19: Firmware enables endpoint modes after the host configures the device.
// R20: Control endpoint keeps three flags for SETUP, IN and OUT seen.
// R21: Firmware keeps the non-control endpoint out of SETUP-accepting modes.
// R22: An ACKed transaction locks mode and count writes until a CPU read of that endpoint's mode or count register.
// R23: IN and OUT flags update at transaction end, SETUP at data start.
// R24: Endpoint event on completed transaction or bad-CRC OUT or SETUP.
// R25: The mode at token arrival applies; engine rewrites act on the next token.
// R26: Mode rewrites happen only on a completed ACK, never on NAK or STALL.
module usb_endpoint_mode_responder
    import usb_mode_pkg::*;
#(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Token and packet events from the serial engine
    input  wire logic             tok_valid,
    input  wire tok_pid_t         tok_pid,
    input  wire logic             tok_ep,
    input  wire logic             data_start,
    input  wire logic             data_end,
    input  wire logic             data_crc_ok,
    input  wire logic             data_zero_len,
    input  wire logic             data_toggle,
    input  wire logic             host_ack,
    input  wire logic             xact_abort,
    // Response to the serial engine
    output logic                  resp_valid,
    output resp_kind_t            resp_kind,
    output logic [CNT_W-1:0]      resp_count,
    output logic [1:0]            ep_event
);

    initial begin
        if (CNT_W < 1 || CNT_W > 8) begin
            $error("CNT_W must be 1 to 8");
        end
    end

    typedef struct packed {
        fsm_t             fsm;
        logic             ep;
        tok_pid_t         pid;
        logic [3:0]       mode;
        logic             stl;
        logic [3:0]       mode0;
        logic [3:0]       mode1;
        logic             stall1;
        logic [CNT_W-1:0] cnt0;
        logic [CNT_W-1:0] cnt1;
        logic [2:0]       pidf;
        logic [1:0]       lock;
        logic             rv;
        resp_kind_t       rk;
        logic [CNT_W-1:0] rc;
        logic [1:0]       evt;
        logic             rdy;
        logic             err;
        logic [31:0]      rdata;
    } st_t;

    st_t s_q;
    st_t s_d;

    // Mode and count that a token arriving now would see
    logic [3:0]       cur_mode;
    logic [CNT_W-1:0] cur_cnt;
    logic             cur_stl;
    act_t             tok_act;
    act_t             lat_act;
    assign cur_mode = tok_ep ? s_q.mode1 : s_q.mode0;
    assign cur_cnt  = tok_ep ? s_q.cnt1 : s_q.cnt0;
    assign cur_stl  = tok_ep & s_q.stall1;
    assign tok_act  = decode(cur_mode, tok_pid, cur_stl); // R01
    assign lat_act  = decode(s_q.mode, s_q.pid, s_q.stl);

    // Next state: bus side first, engine last so hardware sets win
    always_comb begin
        logic       acc;
        logic       rw;
        logic       ack;
        logic       fin;
        logic [3:0] newm;
        logic [7:0] a;
        s_d  = s_q;
        acc  = psel & penable & s_q.rdy;
        rw   = 1'b0;
        ack  = 1'b0;
        fin  = 1'b0;
        newm = s_q.mode;
        a    = paddr[7:0];
        s_d.rv  = 1'b0;
        s_d.evt = 2'b00;
        s_d.rdy = 1'b0;
        s_d.err = 1'b0;
        // Setup phase: decode and prepare read data
        if (psel && !penable) begin
            s_d.rdy   = 1'b1;
            s_d.rdata = 32'h0000_0000;
            s_d.err   = |paddr[31:8];
            case (a)
                OFS_MODE0: s_d.rdata[3:0] = s_q.mode0;
                OFS_CNT0:  s_d.rdata[CNT_W-1:0] = s_q.cnt0;
                OFS_MODE1: s_d.rdata[7:0] = {s_q.stall1, 3'h0, s_q.mode1};
                OFS_CNT1:  s_d.rdata[CNT_W-1:0] = s_q.cnt1;
                OFS_STAT: begin
                    s_d.rdata[ST_OUT:ST_SETUP] = s_q.pidf;
                    s_d.rdata[ST_LOCK0]        = s_q.lock[0];
                    s_d.rdata[ST_LOCK1]        = s_q.lock[1];
                end
                default:   s_d.err = 1'b1;
            endcase
        end
        // Access phase: writes and unlocking reads
        if (acc && !s_q.err) begin
            if (!pwrite) begin
                if (a == OFS_MODE0 || a == OFS_CNT0) s_d.lock[0] = 1'b0; // R22
                if (a == OFS_MODE1 || a == OFS_CNT1) s_d.lock[1] = 1'b0; // R22
            end else begin
                case (a)
                    OFS_MODE0: if (!s_q.lock[0]) s_d.mode0 = pwdata[3:0]; // R22
                    OFS_CNT0:  if (!s_q.lock[0]) s_d.cnt0 = pwdata[CNT_W-1:0];
                    OFS_MODE1: begin
                        if (!s_q.lock[1]) begin
                            s_d.mode1  = pwdata[3:0];
                            s_d.stall1 = pwdata[STALL_BIT];
                        end
                    end
                    OFS_CNT1:  if (!s_q.lock[1]) s_d.cnt1 = pwdata[CNT_W-1:0];
                    OFS_STAT:  s_d.pidf = s_q.pidf & ~pwdata[ST_OUT:ST_SETUP];
                    default:   ;
                endcase
            end
        end
        // Transaction engine
        case (s_q.fsm)
            S_IDLE: begin
                if (tok_valid) begin
                    // Latch the mode seen at token time
                    s_d.ep   = tok_ep; // R25
                    s_d.pid  = tok_pid;
                    s_d.mode = cur_mode;
                    s_d.stl  = cur_stl;
                    if (tok_pid == PID_IN) begin
                        case (tok_act)
                            A_NAK, A_STL: begin
                                s_d.rv = 1'b1;
                                s_d.rk = (tok_act == A_NAK) ? RSP_NAK : RSP_STALL; // R03 R04 R08
                                fin    = 1'b1;
                            end
                            A_ZERO: begin
                                s_d.rv  = 1'b1;
                                s_d.rk  = RSP_DATA;
                                s_d.rc  = '0; // R11
                                s_d.fsm = S_HACK;
                            end
                            A_CNT: begin
                                s_d.rv  = 1'b1;
                                s_d.rk  = RSP_DATA;
                                s_d.rc  = cur_cnt; // R10
                                s_d.fsm = S_HACK;
                            end
                            default: ; // R02 R12
                        endcase
                    end else if (tok_act != A_IGN) begin
                        s_d.fsm = S_DATA;
                    end
                end
            end
            S_DATA: begin
                // SETUP flag moves as soon as the data packet begins
                if (data_start && s_q.pid == PID_SETUP && !s_q.ep) begin
                    s_d.pidf[ST_SETUP] = 1'b1; // R23
                end
                if (xact_abort) begin
                    s_d.fsm = S_IDLE;
                end else if (data_end) begin
                    s_d.fsm = S_IDLE;
                    case (lat_act)
                        A_ACC: ack = data_crc_ok; // R12
                        A_ALW: ack = 1'b1; // R05
                        A_NAK, A_STL: begin
                            if (data_crc_ok) begin
                                s_d.rv = 1'b1;
                                s_d.rk = (lat_act == A_NAK) ? RSP_NAK : RSP_STALL;
                                fin    = 1'b1;
                            end
                        end
                        A_CHK: begin
                            // Bad CRC stays silent, bad shape is stalled
                            if (data_crc_ok && data_zero_len && data_toggle) begin
                                ack = 1'b1; // R09
                            end else if (data_crc_ok) begin
                                s_d.rv = 1'b1;
                                s_d.rk = RSP_STALL; // R09
                                fin    = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                    if (!data_crc_ok && lat_act != A_ALW) begin
                        s_d.evt[s_q.ep] = 1'b1; // R24
                    end
                    if (ack) begin
                        s_d.rv = 1'b1;
                        s_d.rk = RSP_ACK;
                        fin    = 1'b1;
                        rw     = 1'b1;
                        if (s_q.pid == PID_SETUP) begin
                            newm = (s_q.mode != M_DISABLE) ? M_NAK_IO : s_q.mode; // R13
                        end else begin
                            case (s_q.mode)
                                M_AO_NI:   newm = M_NAK_IO;  // R14
                                M_ACK_OUT: newm = M_NAK_OUT; // R14
                                M_AI_SO:   newm = M_NI_SO;   // R16
                                default:   rw = 1'b0;
                            endcase
                        end
                    end
                end
            end
            S_HACK: begin
                if (xact_abort) begin
                    s_d.fsm = S_IDLE;
                end else if (host_ack) begin
                    s_d.fsm = S_IDLE;
                    fin     = 1'b1;
                    ack     = 1'b1;
                    rw      = 1'b1;
                    case (s_q.mode)
                        M_ACK_IN: newm = M_NAK_IN; // R15
                        M_AI_SO:  newm = M_NI_SO;  // R16
                        default:  rw = 1'b0;
                    endcase
                end
            end
            default: s_d.fsm = S_IDLE;
        endcase
        // Completion effects: flags, event, lock and rewrite
        if (fin) begin
            s_d.evt[s_d.ep] = 1'b1; // R24
            if (!s_d.ep && s_d.pid == PID_IN) s_d.pidf[ST_IN] = 1'b1; // R20 R23
            if (!s_d.ep && s_d.pid == PID_OUT) s_d.pidf[ST_OUT] = 1'b1; // R20 R23
        end
        if (ack) begin
            s_d.lock[s_q.ep] = 1'b1; // R22
        end
        // Rewrites only on ACK; a NAK or STALL leaves the field alone
        if (rw) begin
            if (s_q.ep) s_d.mode1 = newm; // R26
            else s_d.mode0 = newm;        // R26
        end
    end

    // Single state register; reset puts every endpoint in disabled mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.fsm   <= S_IDLE;
            s_q.mode0 <= MODE_RST; // R18
            s_q.mode1 <= MODE_RST; // R18
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.rdata;
    assign pready     = s_q.rdy;
    assign pslverr    = s_q.err;
    assign resp_valid = s_q.rv;
    assign resp_kind  = s_q.rk;
    assign resp_count = s_q.rc;
    assign ep_event   = s_q.evt;

    // Checks on the engine's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence tok_in_idle;
        s_q.fsm == S_IDLE && tok_valid;
    endsequence

    sequence setup_ok_end;
        s_q.fsm == S_DATA && s_q.pid == PID_SETUP && lat_act == A_ACC && data_end && data_crc_ok && !xact_abort;
    endsequence

    a_disabled_quiet: assert property (tok_in_idle and cur_mode == M_DISABLE |=> !resp_valid && s_q.fsm == S_IDLE) // R02
        else $error("disabled endpoint answered");
    a_nak_in_mode1: assert property (tok_in_idle and tok_pid == PID_IN && cur_mode == M_NAK_IO
        |=> resp_valid && resp_kind == RSP_NAK) // R03
        else $error("mode 0001 IN not NAKed");
    a_stall_in_mode3: assert property (tok_in_idle and tok_pid == PID_IN && cur_mode == M_STL_IO
        |=> resp_valid && resp_kind == RSP_STALL) // R04
        else $error("mode 0011 IN not stalled");
    a_zero_len_in: assert property (tok_in_idle and tok_pid == PID_IN && cur_mode == M_ST_IN
        |=> resp_valid && resp_kind == RSP_DATA && resp_count == '0) // R11
        else $error("zero length reply wrong");
    a_count_in: assert property (tok_in_idle and tok_pid == PID_IN && cur_mode == M_AI_SO
        |=> resp_kind == RSP_DATA && resp_count == $past(cur_cnt)) // R10
        else $error("counted reply has wrong count");
    a_setup_rewrite: assert property (setup_ok_end |=> resp_kind == RSP_ACK
        && (s_q.ep ? s_q.mode1 : s_q.mode0) == M_NAK_IO) // R13
        else $error("valid SETUP not ACKed with rewrite");
    a_in_ack_rewrite: assert property (s_q.fsm == S_HACK && host_ack && !xact_abort && s_q.mode == M_ACK_IN
        |=> (s_q.ep ? s_q.mode1 : s_q.mode0) == M_NAK_IN ##1 s_q.lock[s_q.ep]) // R15
        else $error("mode 1101 not rewritten after IN ACK");
    a_ack_locks: assert property (resp_valid && resp_kind == RSP_ACK |-> s_q.lock[s_q.ep]) // R22
        else $error("ACK did not lock endpoint");
    a_nak_no_rewrite: assert property (tok_in_idle and tok_pid == PID_IN && tok_act == A_NAK && !psel
        |=> $stable(s_q.mode0) && $stable(s_q.mode1)) // R26
        else $error("NAK changed a mode");

endmodule : usb_endpoint_mode_responder

//--- hw/usb_mode_pkg.sv
package usb_mode_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE0 = 8'h00;
    localparam logic [7:0] OFS_CNT0  = 8'h04;
    localparam logic [7:0] OFS_MODE1 = 8'h08;
    localparam logic [7:0] OFS_CNT1  = 8'h0C;
    localparam logic [7:0] OFS_STAT  = 8'h10;
    // Field positions
    localparam int STALL_BIT = 7;
    localparam int ST_SETUP  = 0;
    localparam int ST_IN     = 1;
    localparam int ST_OUT    = 2;
    localparam int ST_LOCK0  = 4;
    localparam int ST_LOCK1  = 5;
    // Mode encodings
    localparam logic [3:0] M_DISABLE = 4'h0;
    localparam logic [3:0] M_NAK_IO  = 4'h1;
    localparam logic [3:0] M_ST_OUT  = 4'h2;
    localparam logic [3:0] M_STL_IO  = 4'h3;
    localparam logic [3:0] M_IGN_IO  = 4'h4;
    localparam logic [3:0] M_RSV_OUT = 4'h5;
    localparam logic [3:0] M_ST_IN   = 4'h6;
    localparam logic [3:0] M_RSV_IN  = 4'h7;
    localparam logic [3:0] M_NAK_OUT = 4'h8;
    localparam logic [3:0] M_ACK_OUT = 4'h9;
    localparam logic [3:0] M_NO_SIN  = 4'hA;
    localparam logic [3:0] M_AO_NI   = 4'hB;
    localparam logic [3:0] M_NAK_IN  = 4'hC;
    localparam logic [3:0] M_ACK_IN  = 4'hD;
    localparam logic [3:0] M_NI_SO   = 4'hE;
    localparam logic [3:0] M_AI_SO   = 4'hF;
    localparam logic [3:0] MODE_RST  = M_DISABLE;

    typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT} tok_pid_t;
    typedef enum logic [2:0] {A_IGN, A_ACC, A_NAK, A_STL, A_CHK, A_ZERO, A_CNT, A_ALW} act_t;
    typedef enum logic [1:0] {RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA} resp_kind_t;
    typedef enum logic [1:0] {S_IDLE, S_DATA, S_HACK} fsm_t;

    // Action for one token type in one mode
    function automatic act_t decode(input logic [3:0] m, input tok_pid_t p, input logic stl);
        act_t s;
        act_t i;
        act_t o;
        s = A_ACC;
        i = A_IGN;
        o = A_IGN;
        case (m)
            M_DISABLE: s = A_IGN;
            M_NAK_IO:  begin i = A_NAK; o = A_NAK; end
            M_ST_OUT:  begin i = A_STL; o = A_CHK; end
            M_STL_IO:  begin i = A_STL; o = A_STL; end
            M_IGN_IO:  ;
            M_RSV_OUT: begin s = A_IGN; o = A_ALW; end
            M_ST_IN:   begin i = A_ZERO; o = A_STL; end
            M_RSV_IN:  begin s = A_IGN; i = A_CNT; end
            M_NAK_OUT: begin s = A_IGN; o = A_NAK; end // R06
            M_ACK_OUT: begin s = A_IGN; o = stl ? A_STL : A_ACC; end
            M_NO_SIN:  begin i = A_ZERO; o = A_NAK; end // R07
            M_AO_NI:   begin i = A_NAK; o = A_ACC; end
            M_NAK_IN:  begin s = A_IGN; i = A_NAK; end
            M_ACK_IN:  begin s = A_IGN; i = stl ? A_STL : A_CNT; end
            M_NI_SO:   begin i = A_NAK; o = A_CHK; end
            default:   begin i = A_CNT; o = A_CHK; end
        endcase
        case (p)
            PID_SETUP: return s;
            PID_IN:    return i;
            default:   return o;
        endcase
    endfunction : decode
endpackage : usb_mode_pkg

//--- verification/usb_host_model.sv
`timescale 1ns/1ps
// Host side of the token link: sends tokens and packets, reads the answer
module usb_host_model
    import usb_mode_pkg::*;
(
    // Clock
    input  logic       pclk,
    // Token and packet events
    output logic       tok_valid,
    output tok_pid_t   tok_pid,
    output logic       tok_ep,
    output logic       data_start,
    output logic       data_end,
    output logic       data_crc_ok,
    output logic       data_zero_len,
    output logic       data_toggle,
    output logic       host_ack,
    output logic       xact_abort,
    // Engine answer
    input  logic       resp_valid,
    input  resp_kind_t resp_kind,
    input  logic [3:0] resp_count
);
    // Quiet link at time zero
    initial begin
        {tok_valid, tok_ep, data_start, data_end, host_ack, xact_abort} = 6'h00;
        {data_crc_ok, data_zero_len, data_toggle} = 3'h0;
        tok_pid = PID_SETUP;
    end

    // One transaction; code 4 means no answer within the window
    task automatic xact(input tok_pid_t pid, input logic ep, zl, tg, crc, ack,
                        output logic [2:0] code, output logic [3:0] cnt);
        int n;
        code = 3'h4;
        cnt  = 4'h0;
        @(posedge pclk);
        tok_valid <= 1'b1;
        tok_pid   <= pid;
        tok_ep    <= ep;
        @(posedge pclk);
        tok_valid <= 1'b0;
        if (pid != PID_IN) begin
            data_start <= 1'b1;
            @(posedge pclk);
            data_start    <= 1'b0;
            data_end      <= 1'b1;
            data_zero_len <= zl;
            data_toggle   <= tg;
            data_crc_ok   <= crc;
            @(posedge pclk);
            data_end      <= 1'b0;
            // Qualifiers lapse with data_end, so show stale-looking values
            data_zero_len <= ~zl;
            data_toggle   <= ~tg;
            data_crc_ok   <= ~crc;
        end
        for (n = 0; n < 4 && code == 3'h4; n++) begin
            @(negedge pclk);
            if (resp_valid === 1'b1) begin
                code = {1'b0, resp_kind};
                cnt  = resp_count;
            end
        end
        // Data sent: host either acknowledges or aborts the transaction
        if (code == 3'h3) begin
            @(posedge pclk);
            host_ack   <= ack;
            xact_abort <= ~ack;
            @(posedge pclk);
            host_ack   <= 1'b0;
            xact_abort <= 1'b0;
        end
        repeat (2) @(posedge pclk);
    endtask : xact
endmodule : usb_host_model

//--- verification/test_usb_endpoint_mode_responder.sv
`timescale 1ns/1ps
module test_usb_endpoint_mode_responder
    import usb_mode_pkg::*;
;
    // Expected answers per mode: 0 ACK, 1 NAK, 2 STALL, 3 DATA, 4 none
    localparam logic [2:0] EXP_IN [16] = '{3'h4, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h3, 3'h3,
                                          3'h4, 3'h4, 3'h3, 3'h1, 3'h1, 3'h3, 3'h1, 3'h3};
    localparam logic [2:0] EXP_OUT [16] = '{3'h4, 3'h1, 3'h0, 3'h2, 3'h4, 3'h0, 3'h2, 3'h4,
                                           3'h1, 3'h0, 3'h1, 3'h0, 3'h4, 3'h4, 3'h0, 3'h0};
    localparam logic [3:0] NXT_OUT [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                           4'h8, 4'h8, 4'hA, 4'h1, 4'hC, 4'hD, 4'hE, 4'hE};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic        pready, pslverr, tok_valid, tok_ep, data_start, data_end, data_crc_ok;
    logic        data_zero_len, data_toggle, host_ack, xact_abort, resp_valid;
    tok_pid_t    tok_pid;
    resp_kind_t  resp_kind;
    logic [3:0]  resp_count, last_cnt;
    logic [1:0]  ep_event;
    int          n_fail = 0, check_count = 0, cycles = 0;
    logic [1:0]  ev_seen = 2'b00;

    // 20 MHz clock
    always #25 pclk = ~pclk;

    // Sticky copy of the one-cycle event pulses
    always @(posedge pclk) begin
        if (presetn) ev_seen <= ev_seen | ep_event;
    end

    usb_endpoint_mode_responder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep),
        .data_start(data_start), .data_end(data_end), .data_crc_ok(data_crc_ok),
        .data_zero_len(data_zero_len), .data_toggle(data_toggle), .host_ack(host_ack),
        .xact_abort(xact_abort), .resp_valid(resp_valid), .resp_kind(resp_kind),
        .resp_count(resp_count), .ep_event(ep_event));

    usb_host_model i_host (.pclk(pclk), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep),
        .data_start(data_start), .data_end(data_end), .data_crc_ok(data_crc_ok),
        .data_zero_len(data_zero_len), .data_toggle(data_toggle), .host_ack(host_ack),
        .xact_abort(xact_abort), .resp_valid(resp_valid), .resp_kind(resp_kind),
        .resp_count(resp_count));

    // Hang guard, well above the thousand or so cycles the tests need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_rsp(input string name, input logic [2:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_rsp

    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {24'h000000, a};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, r, exp);
    endtask : rdc

    task automatic tok(input string name, input tok_pid_t p, input logic ep, zl, tg, crc, ack,
                       input logic [2:0] exp);
        logic [2:0] c;
        i_host.xact(p, ep, zl, tg, crc, ack, c, last_cnt);
        chk_rsp(name, c, exp);
    endtask : tok

    task automatic test_reset();
        logic [31:0] r;
        logic        e;
        rdc("mode0", OFS_MODE0, 32'h0);
        rdc("mode1", OFS_MODE1, 32'h0);
        rdc("status", OFS_STAT, 32'h0);
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        $display("test_reset done");
    endtask : test_reset

    // Every mode against IN, OUT and SETUP on the control endpoint
    task automatic test_tables();
        for (int m = 0; m < 16; m++) begin
            wr(OFS_CNT0, 32'hB);
            wr(OFS_MODE0, m);
            tok("in_resp", PID_IN, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, EXP_IN[m]);
            if (EXP_IN[m] == 3'h3)
                chk("in_count", last_cnt, (m == 6 || m == 10) ? 32'h0 : 32'hB);
            rdc("in_mode", OFS_MODE0, m);
            tok("out_resp", PID_OUT, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, EXP_OUT[m]);
            rdc("out_mode", OFS_MODE0, NXT_OUT[m]);
            wr(OFS_MODE0, m);
            tok("setup_resp", PID_SETUP, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
                (m inside {1, 2, 3, 4, 6, 10, 11, 14, 15}) ? 3'h0 : 3'h4);
            rdc("setup_mode", OFS_MODE0, (m inside {1, 2, 3, 4, 6, 10, 11, 14, 15}) ? 32'h1 : m);
        end
        $display("test_tables done");
    endtask : test_tables

    // Failed status checks: wrong length, wrong toggle, bad CRC
    task automatic test_status_check();
        wr(OFS_MODE0, 32'h2);
        tok("chk_len", PID_OUT, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h2);
        tok("chk_tog", PID_OUT, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 3'h2);
        tok("chk_crc", PID_OUT, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h4);
        rdc("chk_mode", OFS_MODE0, 32'h2);
        $display("test_status_check done");
    endtask : test_status_check

    task automatic test_flags();
        wr(OFS_STAT, 32'h7);
        rdc("flags_clr", OFS_STAT, 32'h0);
        wr(OFS_MODE0, 32'h1);
        tok("f_setup", PID_SETUP, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
        rdc("f_mode", OFS_MODE0, 32'h1);
        tok("f_in", PID_IN, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1);
        tok("f_out", PID_OUT, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1);
        rdc("flags_all", OFS_STAT, 32'h7);
        $display("test_flags done");
    endtask : test_flags

    // Non-control endpoint kept in non-SETUP modes only
    task automatic test_noncontrol();
        wr(OFS_CNT1, 32'h5);
        wr(OFS_MODE1, 32'hD);
        tok("ack_in", PID_IN, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h3);
        chk("ack_in_cnt", last_cnt, 32'h5);
        chk("ev_seen", ev_seen, 32'h3);
        rdc("lock1", OFS_STAT, 32'h27);
        wr(OFS_MODE1, 32'h8);
        rdc("locked_mode", OFS_MODE1, 32'hC);
        wr(OFS_MODE1, 32'h8D);
        tok("stall_in", PID_IN, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
        rdc("stall_mode", OFS_MODE1, 32'h8D);
        wr(OFS_MODE1, 32'h89);
        tok("stall_out", PID_OUT, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
        wr(OFS_MODE1, 32'h9);
        tok("ack_out", PID_OUT, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
        rdc("ack_out_mode", OFS_MODE1, 32'h8);
        wr(OFS_MODE0, 32'hF);
        tok("ctl_in", PID_IN, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h3);
        rdc("ctl_in_mode", OFS_MODE0, 32'hE);
        $display("test_noncontrol done");
    endtask : test_noncontrol

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_tables();
        test_status_check();
        test_flags();
        test_noncontrol();
        summarize();
    end
endmodule : test_usb_endpoint_mode_responder
